//--- test/testbench.sv
`timescale 1ns/1ps
`include "adc_fmt_consts.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_fail++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench;
	logic mclk, srst, adc_enable, external_ref_enable, ref_output_enable;
	logic left_adjust_bit, bipolar_mode_bit, core_done;
	logic [4:0] channel_select_field;
	logic [1:0] reference_select_field;
	logic signed [`RAW_W-1:0] core_raw;
	logic [7:0] result_low_reg, result_high_reg;
	logic result_sign_bit, conversion_done_flag, ref_output_pin_oe_n, ref_output_high;
	logic [1:0] gain_select;
	adc_fmt_pkg::vref_src_type vref_src, exp_src;
	int n_fail = 0;
	int total_checks = 0;
	logic [15:0] last;
	// calibration as software keeps it: gain unsigned in 1/128, offset signed
	logic [7:0] sensor_gain_cal = 8'h80;
	logic signed [7:0] sensor_offset_cal = -8'sd2;
	int temp_c;
	adc_result_format DUT (.mclk(mclk), .srst(srst), .adc_enable(adc_enable),
		.channel_select_field(channel_select_field), .reference_select_field(reference_select_field),
		.external_ref_enable(external_ref_enable), .ref_output_enable(ref_output_enable),
		.left_adjust_bit(left_adjust_bit), .bipolar_mode_bit(bipolar_mode_bit),
		.core_done(core_done), .core_raw(core_raw), .result_low_reg(result_low_reg),
		.result_high_reg(result_high_reg), .result_sign_bit(result_sign_bit),
		.conversion_done_flag(conversion_done_flag), .gain_select(gain_select),
		.vref_src(vref_src), .ref_output_pin_oe_n(ref_output_pin_oe_n),
		.ref_output_high(ref_output_high));
	// ==========================================================
	// clock, 100 ns period
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// one capture; raw is scrambled afterwards so a stale sample cannot pass
	task automatic cap(input logic [4:0] ch, input logic bip, input logic signed [10:0] raw,
		input logic [9:0] ex);
		channel_select_field = ch;
		bipolar_mode_bit = bip;
		core_raw = raw;
		core_done = 1'b1;
		@(negedge mclk);
		core_done = 1'b0;
		core_raw = ~raw;
		last = left_adjust_bit ? {ex, 6'h00} : {6'h00, ex};
		`CHK("done", 1'b1, conversion_done_flag)
		`CHK("result", last, {result_high_reg, result_low_reg})
		`CHK("gain", (ch[4] ? (ch[0] ? 2'h2 : 2'h1) : 2'h0), gain_select)
		`CHK("sign", bip & ch[4] & ex[`SIGN_POS], result_sign_bit)
		@(negedge mclk);
		`CHK("done_low", 1'b0, conversion_done_flag)
		`CHK("held", last, {result_high_reg, result_low_reg})
	endtask
	// watchdog: the whole run needs well under 200 cycles
	initial begin
		#(2000 * 100);
		n_fail++;
		report_and_stop();
	end
	// ==========================================================
	// main sequence
	initial begin
		srst = 1'b1;
		{adc_enable, external_ref_enable, ref_output_enable, left_adjust_bit} = 4'h8;
		bipolar_mode_bit = 1'b0;
		core_done = 1'b0;
		core_raw = 11'h000;
		channel_select_field = 5'h00;
		reference_select_field = 2'h0;
		repeat (2) @(negedge mclk);
		srst = 1'b0;
		`CHK("oe_n_reset", 1'b1, ref_output_pin_oe_n)
		`CHK("src_reset", adc_fmt_pkg::REF_SUPPLY, vref_src)
		// sensor channel on the internal 1.1 V reference, one single conversion
		reference_select_field = `REF_SEL_INT;
		cap(5'h0b, 1'b0, 11'h144, 10'h144);
		`CHK("src_sensor", adc_fmt_pkg::REF_INT_1V1, vref_src)
		temp_c = (int'({result_high_reg, result_low_reg}) - 298 + int'(sensor_offset_cal)) * 128;
		temp_c = temp_c / int'(sensor_gain_cal) + 25;
		`CHK("temperature", 49, temp_c)
		cap(5'h0b, 1'b0, 11'h3ff, 10'h3ff);
		cap(5'h00, 1'b0, -11'sd3, 10'h000);
		cap(5'h05, 1'b1, -11'sd3, 10'h000);
		cap(5'h10, 1'b1, 11'h064, 10'h064);
		cap(5'h11, 1'b0, -11'sd5, 10'h000);
		cap(5'h1f, 1'b1, -11'sd5, 10'h3fb);
		cap(5'h12, 1'b1, 11'sd600, `BIP_MAX);
		cap(5'h13, 1'b1, -11'sd600, `BIP_MIN);
		$display("test formats done");
		// disabled converter ignores the core
		adc_enable = 1'b0;
		core_raw = 11'h007;
		core_done = 1'b1;
		@(negedge mclk);
		core_done = 1'b0;
		@(negedge mclk);
		`CHK("refused", last, {result_high_reg, result_low_reg})
		adc_enable = 1'b1;
		// left adjust reshapes a stored result without a new capture
		left_adjust_bit = 1'b1;
		@(negedge mclk);
		`CHK("left", {`BIP_MIN, 6'h00}, {result_high_reg, result_low_reg})
		cap(5'h1c, 1'b0, 11'h2a5, 10'h2a5);
		$display("test adjust done");
		// every combination of converter on, output enable and selection
		// the bench puts no pull-up or driver of its own on the reference pin
		for (int i = 0; i < 16; i++) begin
			{adc_enable, ref_output_enable, reference_select_field} = i[3:0];
			@(negedge mclk);
			exp_src = i[0] ? (i[1] ? adc_fmt_pkg::REF_INT_2V56 : adc_fmt_pkg::REF_INT_1V1)
				: adc_fmt_pkg::REF_SUPPLY;
			`CHK("src", exp_src, vref_src)
			`CHK("oe_n", ~(i[3] & i[2] & i[0]), ref_output_pin_oe_n)
			if (i[3] & i[2] & i[0]) `CHK("ref_high", i[1], ref_output_high)
		end
		external_ref_enable = 1'b1;
		reference_select_field = 2'h2;
		@(negedge mclk);
		`CHK("src_ext", adc_fmt_pkg::REF_EXTERNAL, vref_src)
		$display("test reference done");
		report_and_stop();
	end
endmodule

//--- verilog/adc_fmt_consts.svh
`ifndef ADC_FMT_CONSTS_SVH
`define ADC_FMT_CONSTS_SVH
// ==========================================================
// widths and field positions
`define RES_W 10
`define RAW_W 11
`define DIFF_BIT 4
`define GAIN_BIT 0
`define SIGN_POS 9
`define LEFT_PAD 6
`define RES_MAX 10'h3ff
`define BIP_MAX 10'h1ff
`define BIP_MIN 10'h200
`define REF_SEL_INT 2'h1
`define REF_SEL_HIGH 2'h3
`define LOW_SEL_BIT 0
`define HIGH_SEL_BIT 1
`endif

//--- verilog/adc_fmt_pkg.sv
package adc_fmt_pkg;
	// reference source that feeds the converter
	typedef enum logic [1:0] {REF_SUPPLY, REF_EXTERNAL, REF_INT_1V1, REF_INT_2V56} vref_src_type;
	// result encodings
	typedef enum logic [1:0] {ENC_SINGLE, ENC_UNIPOLAR, ENC_BIPOLAR} encoding_type;
endpackage

//--- verilog/adc_result_format.sv
`timescale 1ns/1ps
`include "adc_fmt_consts.svh"
// ==========================================================
// result presentation and reference output control
module adc_result_format (
	input wire logic mclk,
	input wire logic srst,
	input wire logic adc_enable,
	input wire logic [4:0] channel_select_field,
	input wire logic [1:0] reference_select_field,
	input wire logic external_ref_enable,
	input wire logic ref_output_enable,
	input wire logic left_adjust_bit,
	input wire logic bipolar_mode_bit,
	input wire logic core_done,
	input wire logic signed [`RAW_W-1:0] core_raw,
	output logic [7:0] result_low_reg,
	output logic [7:0] result_high_reg,
	output logic result_sign_bit,
	output logic conversion_done_flag,
	output logic [1:0] gain_select,
	output adc_fmt_pkg::vref_src_type vref_src,
	output logic ref_output_pin_oe_n,
	output logic ref_output_high
);
	typedef struct packed {
		logic [`RES_W-1:0] result;
		logic bipolar_result;
		logic done;
		logic [7:0] lo;
		logic [7:0] hi;
		logic sign;
		logic [1:0] gain;
		adc_fmt_pkg::vref_src_type vsrc;
		logic oe_n;
		logic high;
	} state_type;

	state_type st;
	state_type next_st;
	logic [`RES_W-1:0] shaped;
	adc_fmt_pkg::encoding_type enc;
	logic differential;

	assign differential = channel_select_field[`DIFF_BIT];

	result_shaper #(.RAW_WIDTH(`RAW_W)) shaper (
		.raw(core_raw),
		.differential(differential),
		.bipolar(bipolar_mode_bit),
		.code(shaped),
		.encoding(enc)
	);

	// ==========================================================
	// next-state logic
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		// capture only at completion; held otherwise
		if (core_done && adc_enable) begin
			next_st.result = shaped;
			next_st.bipolar_result = (enc == adc_fmt_pkg::ENC_BIPOLAR);
			next_st.done = 1'b1;
		end
		// left adjust is applied to the held result every cycle
		if (left_adjust_bit) begin
			next_st.hi = next_st.result[`RES_W-1:2];
			next_st.lo = {next_st.result[1:0], `LEFT_PAD'h00};
		end else begin
			next_st.hi = {6'h00, next_st.result[`RES_W-1:8]};
			next_st.lo = next_st.result[7:0];
		end
		next_st.sign = next_st.bipolar_result & next_st.result[`SIGN_POS];
		// odd code in the differential range selects the higher gain
		next_st.gain = differential ? (channel_select_field[`GAIN_BIT] ? 2'h2 : 2'h1) : 2'h0;
		// reference selection decode
		if (!reference_select_field[`LOW_SEL_BIT]) begin
			next_st.vsrc = external_ref_enable ? adc_fmt_pkg::REF_EXTERNAL
				: adc_fmt_pkg::REF_SUPPLY;
		end else if (reference_select_field[`HIGH_SEL_BIT]) begin
			next_st.vsrc = adc_fmt_pkg::REF_INT_2V56;
		end else begin
			next_st.vsrc = adc_fmt_pkg::REF_INT_1V1;
		end
		// pin drive: enable, converter on, internal selection only
		next_st.oe_n = 1'b1;
		next_st.high = 1'b0;
		if (ref_output_enable && adc_enable
			&& reference_select_field[`LOW_SEL_BIT]) begin
			next_st.oe_n = 1'b0;
			next_st.high = reference_select_field[`HIGH_SEL_BIT];
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge mclk) begin
		if (srst) begin
			st <= '{result: '0, bipolar_result: 1'b0, done: 1'b0, lo: 8'h00, hi: 8'h00,
				sign: 1'b0, gain: 2'h0, vsrc: adc_fmt_pkg::REF_SUPPLY, oe_n: 1'b1, high: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign result_low_reg = st.lo;
	assign result_high_reg = st.hi;
	assign result_sign_bit = st.sign;
	assign conversion_done_flag = st.done;
	assign gain_select = st.gain;
	assign vref_src = st.vsrc;
	assign ref_output_pin_oe_n = st.oe_n;
	assign ref_output_high = st.high;

	// ==========================================================
	// checks
	property p_done_pulse;
		@(posedge mclk) disable iff (srst) (core_done && adc_enable) |=> conversion_done_flag;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done flag missing");

	property p_hold;
		@(posedge mclk) disable iff (srst)
			!(core_done && adc_enable) |=> ($stable(st.result) && $stable(result_sign_bit));
	endproperty
	a_hold: assert property (p_hold) else $error("result changed without completion");

	property p_pin_off;
		@(posedge mclk) disable iff (srst) (!ref_output_enable || !adc_enable) |=> ref_output_pin_oe_n;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");

	property p_pin_high;
		@(posedge mclk) disable iff (srst)
			(ref_output_enable && adc_enable && reference_select_field == `REF_SEL_HIGH)
			|=> (!ref_output_pin_oe_n && ref_output_high);
	endproperty
	a_pin_high: assert property (p_pin_high) else $error("2.56 V output missing");

	property p_left;
		@(posedge mclk) disable iff (srst)
			left_adjust_bit |=> (result_high_reg == st.result[`RES_W-1:2]);
	endproperty
	a_left: assert property (p_left) else $error("left adjust wrong");

	property p_right;
		@(posedge mclk) disable iff (srst)
			!left_adjust_bit |=> ({result_high_reg, result_low_reg} == {`LEFT_PAD'h00, st.result});
	endproperty
	a_right: assert property (p_right) else $error("right adjust wrong");

	property p_unip_sat;
		@(posedge mclk) disable iff (srst)
			(core_done && adc_enable && !bipolar_mode_bit && core_raw[`RAW_W-1])
			|=> (st.result == '0);
	endproperty
	a_unip_sat: assert property (p_unip_sat) else $error("negative not saturated");

	property p_sign;
		@(posedge mclk) disable iff (srst)
			(core_done && adc_enable && differential && bipolar_mode_bit && core_raw < 0)
			|=> result_sign_bit;
	endproperty
	a_sign: assert property (p_sign) else $error("sign bit not set");

	property p_gain;
		@(posedge mclk) disable iff (srst)
			channel_select_field[`DIFF_BIT]
			|=> (gain_select == ($past(channel_select_field[`GAIN_BIT]) ? 2'h2 : 2'h1));
	endproperty
	a_gain: assert property (p_gain) else $error("no gain for differential");

	property p_int11;
		@(posedge mclk) disable iff (srst)
			(reference_select_field == `REF_SEL_INT) |=> (vref_src == adc_fmt_pkg::REF_INT_1V1);
	endproperty
	a_int11: assert property (p_int11) else $error("1.1 V select wrong");

	// a refused completion must not look like a finished conversion
	property p_refused;
		@(posedge mclk) disable iff (srst)
			(core_done && !adc_enable) |=> !conversion_done_flag;
	endproperty
	a_refused: assert property (p_refused) else $error("done flag while disabled");

	// sign only carries meaning for bipolar differential captures
	property p_sign_plain;
		@(posedge mclk) disable iff (srst)
			(core_done && adc_enable && !(differential && bipolar_mode_bit))
			|=> !result_sign_bit;
	endproperty
	a_sign_plain: assert property (p_sign_plain) else $error("sign set outside bipolar");

	property p_bip_top;
		@(posedge mclk) disable iff (srst)
			(core_done && adc_enable && differential && bipolar_mode_bit
			&& core_raw > $signed({1'b0, `BIP_MAX})) |=> (st.result == `BIP_MAX);
	endproperty
	a_bip_top: assert property (p_bip_top) else $error("bipolar top not clamped");

	property p_bip_bottom;
		@(posedge mclk) disable iff (srst)
			(core_done && adc_enable && differential && bipolar_mode_bit
			&& core_raw < -$signed({1'b0, `BIP_MIN})) |=> (st.result == `BIP_MIN);
	endproperty
	a_bip_bottom: assert property (p_bip_bottom) else $error("bipolar bottom not clamped");

	property p_ext_ref;
		@(posedge mclk) disable iff (srst)
			(!reference_select_field[`LOW_SEL_BIT] && external_ref_enable)
			|=> (vref_src == adc_fmt_pkg::REF_EXTERNAL);
	endproperty
	a_ext_ref: assert property (p_ext_ref) else $error("external reference not chosen");

	property p_supply;
		@(posedge mclk) disable iff (srst)
			(!reference_select_field[`LOW_SEL_BIT] && !external_ref_enable)
			|=> (vref_src == adc_fmt_pkg::REF_SUPPLY);
	endproperty
	a_supply: assert property (p_supply) else $error("supply reference not chosen");

	property p_pin_int;
		@(posedge mclk) disable iff (srst)
			(ref_output_enable && adc_enable && reference_select_field == `REF_SEL_INT)
			|=> (!ref_output_pin_oe_n && !ref_output_high);
	endproperty
	a_pin_int: assert property (p_pin_int) else $error("1.1 V output missing");

	property p_gain_single;
		@(posedge mclk) disable iff (srst)
			!channel_select_field[`DIFF_BIT] |=> (gain_select == 2'h0);
	endproperty
	a_gain_single: assert property (p_gain_single) else $error("gain on single input");

	c_bipolar: cover property (@(posedge mclk) conversion_done_flag && st.bipolar_result);
	c_unip_sat: cover property (@(posedge mclk) conversion_done_flag && st.result == '0);
	c_ext_ref: cover property (@(posedge mclk) vref_src == adc_fmt_pkg::REF_EXTERNAL);
	c_pin_on: cover property (@(posedge mclk) !ref_output_pin_oe_n);
	c_left: cover property (@(posedge mclk) conversion_done_flag && left_adjust_bit);
endmodule

//--- verilog/result_shaper.sv
`timescale 1ns/1ps
`include "adc_fmt_consts.svh"
// ==========================================================
// combinational coding of a signed raw sample into the 10-bit result
module result_shaper #(
	parameter int RAW_WIDTH = `RAW_W
) (
	input wire logic signed [RAW_WIDTH-1:0] raw,
	input wire logic differential,
	input wire logic bipolar,
	output logic [`RES_W-1:0] code,
	output adc_fmt_pkg::encoding_type encoding
);
	// the clamp bounds assume the core's signed word width
	if (RAW_WIDTH != `RAW_W) begin : g_width_check
		$error("raw width must be 11");
	end
	// core delivers signed difference; clamp per mode
	always_comb begin
		code = '0;
		encoding = adc_fmt_pkg::ENC_SINGLE;
		if (differential && bipolar) begin
			encoding = adc_fmt_pkg::ENC_BIPOLAR;
			// two's complement range 200..1ff, sign in bit nine
			if (raw > $signed({2'h0, `BIP_MAX})) begin
				code = `BIP_MAX;
			end else if (raw < -$signed({2'h0, `BIP_MIN})) begin
				code = `BIP_MIN;
			end else begin
				code = raw[`RES_W-1:0];
			end
		end else begin
			if (differential) begin
				encoding = adc_fmt_pkg::ENC_UNIPOLAR;
			end
			// negative difference saturates to zero, top at 3ff
			if (raw[RAW_WIDTH-1]) begin
				code = '0;
			end else begin
				code = raw[`RES_W-1:0];
			end
		end
	end
endmodule
